// File: logic/gps_pkg.sv
package gps_pkg;

    localparam int GPS_PINS  = 8;
    localparam int AW        = 5;
    localparam int DW        = 8;
    localparam int PIN_IDX_W = 3;
    localparam int RMW_OP_W  = 2;

    // Register map, byte offsets on the plain register port
    localparam logic [AW-1:0] ADDR_DIR     = 5'h00;
    localparam logic [AW-1:0] ADDR_DIRSET  = 5'h01;
    localparam logic [AW-1:0] ADDR_DIRCLR  = 5'h02;
    localparam logic [AW-1:0] ADDR_DIRTGL  = 5'h03;
    localparam logic [AW-1:0] ADDR_OUT     = 5'h04;
    localparam logic [AW-1:0] ADDR_OUTSET  = 5'h05;
    localparam logic [AW-1:0] ADDR_OUTCLR  = 5'h06;
    localparam logic [AW-1:0] ADDR_OUTTGL  = 5'h07;
    localparam logic [AW-1:0] ADDR_IN      = 5'h08;
    localparam logic [AW-1:0] ADDR_MASK0   = 5'h09;
    localparam logic [AW-1:0] ADDR_MASK1   = 5'h0A;
    localparam logic [AW-1:0] ADDR_FLAGS   = 5'h0B;
    localparam logic [AW-1:0] ADDR_MULTI   = 5'h0C;
    localparam logic [AW-1:0] ADDR_REMAP   = 5'h0D;
    localparam logic [AW-1:0] ADDR_CLKOUT  = 5'h0E;
    localparam logic [AW-1:0] ADDR_EVOUT   = 5'h0F;
    localparam logic [AW-1:0] ADDR_PINCFG0 = 5'h10;

    localparam logic [DW-1:0] RST_BYTE = 8'h00;

    // Pin configuration byte
    localparam int CFG_SENSE_LSB = 0;
    localparam int CFG_SENSE_W   = 2;
    localparam int CFG_DRV_LSB   = 2;
    localparam int CFG_DRV_W     = 3;
    localparam int CFG_INV_BIT   = 6;

    // Clock and event output bytes
    localparam int CLK_SRC_LSB = 0;
    localparam int CLK_SRC_W   = 2;
    localparam int CLK_PIN_LSB = 2;
    localparam int EV_EN_BIT   = 0;
    localparam int EV_PIN_LSB  = 1;
    localparam int EV_CH_LSB   = 4;

    // Remap byte and the pins each function moves
    localparam int REMAP_W        = 3;
    localparam int REMAP_TC_BIT   = 0;
    localparam int REMAP_USART_BIT = 1;
    localparam int REMAP_SPI_BIT  = 2;
    localparam logic [PIN_IDX_W-1:0] REMAP_NIBBLE   = 3'h4;
    localparam logic [PIN_IDX_W-1:0] REMAP_PAIR     = 3'h1;
    localparam logic [PIN_IDX_W-1:0] USART_PIN_SEL  = 3'h2;
    localparam logic [PIN_IDX_W-1:0] SPI_PIN_MASK   = 3'h6;
    localparam logic [PIN_IDX_W-1:0] SPI_PIN_BASE   = 3'h4;

    typedef enum logic [1:0] {
        GPS_SENSE_BOTH = 2'b00,
        GPS_SENSE_RISE = 2'b01,
        GPS_SENSE_FALL = 2'b10,
        GPS_SENSE_LOW  = 2'b11
    } gps_sense_type;

    typedef enum logic [2:0] {
        GPS_DRV_TOTEM   = 3'b000,
        GPS_DRV_KEEPER  = 3'b001,
        GPS_DRV_PULLDN  = 3'b010,
        GPS_DRV_PULLUP  = 3'b011,
        GPS_DRV_WOR     = 3'b100,
        GPS_DRV_WAND    = 3'b101,
        GPS_DRV_WOR_PD  = 3'b110,
        GPS_DRV_WAND_PU = 3'b111
    } gps_drive_type;

    typedef enum logic [1:0] {
        GPS_CLK_OFF = 2'b00,
        GPS_CLK_PER = 2'b01,
        GPS_CLK_RTC = 2'b10
    } gps_clksrc_type;

    typedef enum logic [1:0] {
        GPS_RMW_WRITE = 2'b00,
        GPS_RMW_SET   = 2'b01,
        GPS_RMW_CLR   = 2'b10,
        GPS_RMW_TGL   = 2'b11
    } gps_rmw_type;

    function automatic logic gps_sense_hit(input gps_sense_type mode, input logic now, input logic last);
        unique case (mode)
            GPS_SENSE_BOTH: return now ^ last;
            GPS_SENSE_RISE: return now & ~last;
            GPS_SENSE_FALL: return ~now & last;
            GPS_SENSE_LOW:  return ~now;
        endcase
    endfunction

    function automatic logic gps_is_pincfg(input logic [AW-1:0] a);
        return a[AW-1:PIN_IDX_W] == ADDR_PINCFG0[AW-1:PIN_IDX_W];
    endfunction

    function automatic logic [DW-1:0] gps_rmw(input logic [DW-1:0] cur, input logic [DW-1:0] wd,
                                              input logic [AW-1:0] a);
        unique case (gps_rmw_type'(a[RMW_OP_W-1:0]))
            GPS_RMW_WRITE: return wd;
            GPS_RMW_SET:   return cur | wd;
            GPS_RMW_CLR:   return cur & ~wd;
            GPS_RMW_TGL:   return cur ^ wd;
        endcase
    endfunction

    // Which default-location alternate function lands on this pin
    function automatic logic [PIN_IDX_W-1:0] gps_remap_src(input logic [PIN_IDX_W-1:0] pin,
                                                          input logic [REMAP_W-1:0] rm);
        logic [PIN_IDX_W-1:0] s;
        s = pin;
        if (rm[REMAP_TC_BIT]) s = pin ^ REMAP_NIBBLE;
        if (rm[REMAP_USART_BIT] && (pin & USART_PIN_SEL) != '0) s = pin ^ REMAP_NIBBLE;
        if (rm[REMAP_SPI_BIT] && (pin & SPI_PIN_MASK) == SPI_PIN_BASE) s = pin ^ REMAP_PAIR;
        return s;
    endfunction

endpackage

// File: logic/gps_sync2.sv
`timescale 1ns/1ps
module gps_sync2
    import gps_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic [GPS_PINS-1:0] d,
    output logic      [GPS_PINS-1:0] q
);
    logic [GPS_PINS-1:0] meta;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

    a_sync_two_stage: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> ##1 q == $past(d, 2)) else $error("synchroniser delay is not two cycles");
endmodule

// File: logic/gps_sense.sv
`timescale 1ns/1ps
module gps_sense
    import gps_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  en,
    input  wire logic [GPS_PINS-1:0]   level,
    input  wire logic [2*GPS_PINS-1:0] mode,
    output logic      [GPS_PINS-1:0]   detect
);
    logic [GPS_PINS-1:0] prev;
    logic                primed;
    logic [1:0]          warm_up;
    logic [GPS_PINS-1:0] next_detect;

    always_comb begin
        for (int k = 0; k < GPS_PINS; k++) begin
            next_detect[k] = en & primed & gps_sense_hit(gps_sense_type'(mode[2*k +: 2]), level[k], prev[k]);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev    <= '0;
            primed  <= 1'b0;
            warm_up <= '0;
            detect  <= '0;
        end else begin
            // Hold off until both synchroniser stages carry real pin levels
            prev    <= level;
            warm_up <= {warm_up[0], 1'b1};
            primed  <= warm_up[1];
            detect <= next_detect;
        end
    end

    a_low_level_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (en && primed && mode[1:0] == GPS_SENSE_LOW && !level[0]) |=> detect[0])
        else $error("low level on pin 0 not detected");
    a_rise_only: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode[1:0] == GPS_SENSE_RISE && !(level[0] && !prev[0])) |=> !detect[0])
        else $error("rising sense fired without a rising edge");
endmodule

// File: logic/gps_port.sv
`timescale 1ns/1ps
// Behaviour
// - Eight pins, 0 to 7, each configured
// - Per-pin direction, driver style and pull
// - Sense both, rising, falling or low
// - Synchronous sensing with clock, asynchronous without
// - Asynchronous change gives wake-up without clocks
// - Two port interrupts, each with pin mask
// - Set, clear, toggle locations change selected bits
// - One configuration write can hit several pins
// - Direction change leaves other pins untouched
// - Bus-keeper weakly holds last pin level
// - Inverted pin value feeds the sense logic
// - Enabled alternate function overrides pin
// - Peripheral clock, counter clock or event out
// - Serial and timer pins can be remapped
// - Selectable pulls on inputs, wired-OR/AND
module gps_port
    import gps_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire logic [AW-1:0]       addr,
    input  wire logic [DW-1:0]       wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [DW-1:0]       rdata,
    input  wire logic [GPS_PINS-1:0] pin_in,
    output logic      [GPS_PINS-1:0] pin_out,
    output logic      [GPS_PINS-1:0] pin_oe_n,
    output logic      [GPS_PINS-1:0] pin_pull_up,
    output logic      [GPS_PINS-1:0] pin_pull_down,
    input  wire logic [GPS_PINS-1:0] alt_en,
    input  wire logic [GPS_PINS-1:0] alt_dir,
    input  wire logic [GPS_PINS-1:0] alt_out,
    output logic      [REMAP_W-1:0]  remap_sel,
    input  wire logic                per_clk,
    input  wire logic                rtc_clk,
    input  wire logic [GPS_PINS-1:0] evt_ch,
    input  wire logic                port_clk_en,
    output logic      [GPS_PINS-1:0] pin_evt,
    output logic                     port_irq0,
    output logic                     port_irq1,
    output logic                     wake_req
);
    logic                rst_meta;
    logic                rst_n;

    logic [DW-1:0]       dir;
    logic [DW-1:0]       out;
    logic [DW-1:0]       mask0;
    logic [DW-1:0]       mask1;
    logic [DW-1:0]       flags;
    logic [DW-1:0]       multi;
    logic [REMAP_W-1:0]  remap;
    logic [DW-1:0]       clk_cfg;
    logic [DW-1:0]       ev_cfg;
    logic [DW-1:0]       pin_cfg      [GPS_PINS];
    logic [GPS_PINS-1:0] last_level;
    logic [GPS_PINS-1:0] last_sensed;

    logic [DW-1:0]       next_dir;
    logic [DW-1:0]       next_out;
    logic [DW-1:0]       next_mask0;
    logic [DW-1:0]       next_mask1;
    logic [DW-1:0]       next_flags;
    logic [DW-1:0]       next_multi;
    logic [REMAP_W-1:0]  next_remap;
    logic [DW-1:0]       next_clk_cfg;
    logic [DW-1:0]       next_ev_cfg;
    logic [DW-1:0]       next_pin_cfg [GPS_PINS];
    logic [DW-1:0]       next_rdata;
    logic                next_irq0;
    logic                next_irq1;

    logic [GPS_PINS-1:0]   pin_sync;
    logic [GPS_PINS-1:0]   inv_vec;
    logic [GPS_PINS-1:0]   sensed;
    logic [2*GPS_PINS-1:0] sense_vec;
    logic [GPS_PINS-1:0]   detect;
    logic [GPS_PINS-1:0]   async_hit;
    logic [PIN_IDX_W-1:0]  pin_idx;
    gps_clksrc_type        clk_src;
    logic [PIN_IDX_W-1:0]  clk_pin;
    logic [PIN_IDX_W-1:0]  ev_pin;
    logic [PIN_IDX_W-1:0]  ev_ch;
    logic                  ev_en;
    logic                  clk_val;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    gps_sync2 u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (pin_in),
        .q     (pin_sync)
    );

    assign pin_idx = addr[PIN_IDX_W-1:0];
    assign clk_src = gps_clksrc_type'(clk_cfg[CLK_SRC_LSB +: CLK_SRC_W]);
    assign clk_pin = clk_cfg[CLK_PIN_LSB +: PIN_IDX_W];
    assign ev_en   = ev_cfg[EV_EN_BIT];
    assign ev_pin  = ev_cfg[EV_PIN_LSB +: PIN_IDX_W];
    assign ev_ch   = ev_cfg[EV_CH_LSB +: PIN_IDX_W];
    assign remap_sel = remap;

    always_comb begin
        unique case (clk_src)
            GPS_CLK_PER: clk_val = per_clk;
            GPS_CLK_RTC: clk_val = rtc_clk;
            default:     clk_val = 1'b0;
        endcase
    end

    // Sense path: inverted value, synchronous detector, asynchronous wake path
    for (genvar i = 0; i < GPS_PINS; i++) begin : g_sense
        assign inv_vec[i] = pin_cfg[i][CFG_INV_BIT];
        assign sense_vec[2*i +: 2] = pin_cfg[i][CFG_SENSE_LSB +: CFG_SENSE_W];
        assign async_hit[i] = (mask0[i] | mask1[i])
            & gps_sense_hit(gps_sense_type'(sense_vec[2*i +: 2]), pin_in[i] ^ inv_vec[i], last_sensed[i]);
    end

    assign sensed = pin_sync ^ inv_vec;

    gps_sense u_sense (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .en     (port_clk_en),
        .level  (sensed),
        .mode   (sense_vec),
        .detect (detect)
    );

    assign pin_evt  = detect;
    // Combinational on purpose: with the port clock stopped nothing else may carry it
    assign wake_req = ~port_clk_en & (|async_hit);

    // Register file
    always_comb begin
        next_dir     = dir;
        next_out     = out;
        next_mask0   = mask0;
        next_mask1   = mask1;
        next_flags   = flags;
        next_multi   = multi;
        next_remap   = remap;
        next_clk_cfg = clk_cfg;
        next_ev_cfg  = ev_cfg;
        for (int k = 0; k < GPS_PINS; k++) begin
            next_pin_cfg[k] = pin_cfg[k];
        end
        if (wr) begin
            case (addr)
                ADDR_DIR, ADDR_DIRSET, ADDR_DIRCLR, ADDR_DIRTGL: next_dir = gps_rmw(dir, wdata, addr);
                ADDR_OUT, ADDR_OUTSET, ADDR_OUTCLR, ADDR_OUTTGL: next_out = gps_rmw(out, wdata, addr);
                ADDR_MASK0:  next_mask0   = wdata;
                ADDR_MASK1:  next_mask1   = wdata;
                ADDR_FLAGS:  next_flags   = flags & ~wdata;
                ADDR_MULTI:  next_multi   = wdata;
                ADDR_REMAP:  next_remap   = wdata[REMAP_W-1:0];
                ADDR_CLKOUT: next_clk_cfg = wdata;
                ADDR_EVOUT:  next_ev_cfg  = wdata;
                default: begin
                    if (gps_is_pincfg(addr)) begin
                        for (int k = 0; k < GPS_PINS; k++) begin
                            if (PIN_IDX_W'(k) == pin_idx || multi[k]) next_pin_cfg[k] = wdata;
                        end
                        next_multi = RST_BYTE;
                    end
                end
            endcase
        end
        next_flags = next_flags | detect;
        next_irq0  = |(flags & mask0);
        next_irq1  = |(flags & mask1);
        next_rdata = RST_BYTE;
        if (rd) begin
            case (addr)
                ADDR_DIR, ADDR_DIRSET, ADDR_DIRCLR, ADDR_DIRTGL: next_rdata = dir;
                ADDR_OUT, ADDR_OUTSET, ADDR_OUTCLR, ADDR_OUTTGL: next_rdata = out;
                ADDR_IN:     next_rdata = sensed;
                ADDR_MASK0:  next_rdata = mask0;
                ADDR_MASK1:  next_rdata = mask1;
                ADDR_FLAGS:  next_rdata = flags;
                ADDR_MULTI:  next_rdata = multi;
                ADDR_REMAP:  next_rdata = {{(DW-REMAP_W){1'b0}}, remap};
                ADDR_CLKOUT: next_rdata = clk_cfg;
                ADDR_EVOUT:  next_rdata = ev_cfg;
                default: begin
                    if (gps_is_pincfg(addr)) next_rdata = pin_cfg[pin_idx];
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dir         <= RST_BYTE;
            out         <= RST_BYTE;
            mask0       <= RST_BYTE;
            mask1       <= RST_BYTE;
            flags       <= RST_BYTE;
            multi       <= RST_BYTE;
            remap       <= '0;
            clk_cfg     <= RST_BYTE;
            ev_cfg      <= RST_BYTE;
            rdata       <= RST_BYTE;
            port_irq0   <= 1'b0;
            port_irq1   <= 1'b0;
            last_level  <= '0;
            last_sensed <= '0;
            for (int k = 0; k < GPS_PINS; k++) begin
                pin_cfg[k] <= RST_BYTE;
            end
        end else begin
            dir         <= next_dir;
            out         <= next_out;
            mask0       <= next_mask0;
            mask1       <= next_mask1;
            flags       <= next_flags;
            multi       <= next_multi;
            remap       <= next_remap;
            clk_cfg     <= next_clk_cfg;
            ev_cfg      <= next_ev_cfg;
            rdata       <= next_rdata;
            port_irq0   <= next_irq0;
            port_irq1   <= next_irq1;
            last_level  <= pin_sync;
            last_sensed <= sensed;
            for (int k = 0; k < GPS_PINS; k++) begin
                pin_cfg[k] <= next_pin_cfg[k];
            end
        end
    end

    // Pin drivers
    for (genvar i = 0; i < GPS_PINS; i++) begin : g_pin
        logic [PIN_IDX_W-1:0] src;
        gps_drive_type        drv;
        logic                 dir_i;
        logic                 val_i;
        logic                 drive_i;

        assign src = gps_remap_src(PIN_IDX_W'(i), remap);
        assign drv = gps_drive_type'(pin_cfg[i][CFG_DRV_LSB +: CFG_DRV_W]);

        always_comb begin
            dir_i = dir[i];
            val_i = out[i];
            if (alt_en[src]) begin
                dir_i = alt_dir[src];
                val_i = alt_out[src];
            end
            if (clk_src != GPS_CLK_OFF && clk_pin == PIN_IDX_W'(i)) begin
                dir_i = 1'b1;
                val_i = clk_val;
            end
            if (ev_en && ev_pin == PIN_IDX_W'(i)) begin
                dir_i = 1'b1;
                val_i = evt_ch[ev_ch];
            end
            val_i = val_i ^ inv_vec[i];
            unique case (drv)
                GPS_DRV_WOR, GPS_DRV_WOR_PD:   drive_i = dir_i & val_i;
                GPS_DRV_WAND, GPS_DRV_WAND_PU: drive_i = dir_i & ~val_i;
                default:                       drive_i = dir_i;
            endcase
        end

        assign pin_out[i]       = val_i;
        assign pin_oe_n[i]      = ~drive_i;
        assign pin_pull_up[i]   = ~drive_i & (drv == GPS_DRV_PULLUP || drv == GPS_DRV_WAND_PU
                                              || (drv == GPS_DRV_KEEPER && last_level[i]));
        assign pin_pull_down[i] = ~drive_i & (drv == GPS_DRV_PULLDN || drv == GPS_DRV_WOR_PD
                                              || (drv == GPS_DRV_KEEPER && !last_level[i]));
    end

    sequence s_read_in;
        rd && addr == ADDR_IN;
    endsequence

    sequence s_flag_in_mask1;
        (flags & mask1) != '0;
    endsequence

    a_dir_set_bits: assert property (
        wr && addr == ADDR_DIRSET |=> dir == ($past(dir) | $past(wdata)))
        else $error("direction set location changed wrong bits");
    a_dir_others_kept: assert property (
        wr && addr == ADDR_DIRCLR |=> dir == ($past(dir) & ~$past(wdata)))
        else $error("direction clear disturbed other pins");
    a_out_toggle: assert property (
        wr && addr == ADDR_OUTTGL |=> out == ($past(out) ^ $past(wdata)))
        else $error("output toggle location wrong");
    a_multi_cfg: assert property (
        wr && gps_is_pincfg(addr) && multi[0] |=> pin_cfg[0] == $past(wdata) && multi == RST_BYTE)
        else $error("multi-pin configuration not applied");
    a_flag_set_wins: assert property (
        detect != '0 |=> (flags & $past(detect)) == $past(detect))
        else $error("sense event lost from flags");
    a_irq_mask_one: assert property (
        s_flag_in_mask1 |=> port_irq1)
        else $error("masked flag did not raise second interrupt");
    a_irq_mask_zero: assert property (
        (flags & mask0) == '0 |=> !port_irq0)
        else $error("first interrupt raised without masked flag");
    a_wake_async: assert property (
        !port_clk_en && async_hit != '0 |-> wake_req)
        else $error("asynchronous change gave no wake-up");
    a_sync_mode: assert property (
        port_clk_en |-> !wake_req)
        else $error("wake-up raised while port clock runs");
    a_detect_gated: assert property (
        !port_clk_en |=> detect == '0)
        else $error("synchronous sense active without port clock");
    a_keeper_level: assert property (
        g_pin[1].drv == GPS_DRV_KEEPER && pin_oe_n[1] |-> pin_pull_up[1] == last_level[1]
        && pin_pull_down[1] == !last_level[1])
        else $error("bus-keeper does not follow last level");
    a_read_in_inv: assert property (
        s_read_in |=> rdata == $past(sensed))
        else $error("input read does not show inverted sense value");
    a_alt_override: assert property (
        alt_en[0] && remap == '0 && clk_cfg == RST_BYTE && ev_cfg == RST_BYTE
        |-> pin_out[0] == (alt_out[0] ^ inv_vec[0]))
        else $error("alternate function did not override pin 0");
endmodule

// File: verif/gps_pad_model.sv
`timescale 1ns/1ps
module gps_pad_model
    import gps_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic [GPS_PINS-1:0] pin_out,
    input  wire logic [GPS_PINS-1:0] pin_oe_n,
    input  wire logic [GPS_PINS-1:0] pin_pull_up,
    input  wire logic [GPS_PINS-1:0] pin_pull_down,
    input  wire logic [GPS_PINS-1:0] ext_en,
    input  wire logic [GPS_PINS-1:0] ext_val,
    output logic      [GPS_PINS-1:0] pin_in
);
    logic [GPS_PINS-1:0] flt = 8'h55;

    // A pad that nobody drives or pulls wanders every cycle
    always @(posedge mclk) begin
        flt <= ~flt;
    end

    always_comb begin
        for (int i = 0; i < GPS_PINS; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pull_up[i]) begin
                pin_in[i] = 1'b1;
            end else if (pin_pull_down[i]) begin
                pin_in[i] = 1'b0;
            end else begin
                pin_in[i] = flt[i];
            end
        end
    end
endmodule

// File: verif/gps_port_tb.sv
`timescale 1ns/1ps
module gps_port_tb
    import gps_pkg::*;
;
    logic                mclk;
    logic                rstn;
    logic [AW-1:0]       addr;
    logic [DW-1:0]       wdata;
    logic                wr;
    logic                rd;
    logic [DW-1:0]       rdata;
    logic [GPS_PINS-1:0] pin_in;
    logic [GPS_PINS-1:0] pin_out;
    logic [GPS_PINS-1:0] pin_oe_n;
    logic [GPS_PINS-1:0] pin_pull_up;
    logic [GPS_PINS-1:0] pin_pull_down;
    logic [GPS_PINS-1:0] alt_en;
    logic [GPS_PINS-1:0] alt_dir;
    logic [GPS_PINS-1:0] alt_out;
    logic [REMAP_W-1:0]  remap_sel;
    logic                per_clk;
    logic                rtc_clk;
    logic [GPS_PINS-1:0] evt_ch;
    logic                port_clk_en;
    logic [GPS_PINS-1:0] pin_evt;
    logic                port_irq0;
    logic                port_irq1;
    logic                wake_req;
    logic [GPS_PINS-1:0] ext_en;
    logic [GPS_PINS-1:0] ext_val;
    int                  bad_count = 0;
    int                  checked = 0;
    // Sense mode, invert, start level, end level, flag expected
    logic [5:0]          tab [5] = '{6'b00_0_01_1, 6'b01_0_10_0, 6'b10_0_10_1, 6'b11_0_10_1, 6'b01_1_10_1};

    gps_port DUT (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
        .pin_pull_down(pin_pull_down), .alt_en(alt_en), .alt_dir(alt_dir), .alt_out(alt_out),
        .remap_sel(remap_sel), .per_clk(per_clk), .rtc_clk(rtc_clk), .evt_ch(evt_ch),
        .port_clk_en(port_clk_en), .pin_evt(pin_evt), .port_irq0(port_irq0), .port_irq1(port_irq1),
        .wake_req(wake_req));
    gps_pad_model pads (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
        .pin_pull_down(pin_pull_down), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        chk(rdata & m, exp);
    endtask

    task automatic results;
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge mclk);
        bad_count++;
        results;
    end

    initial begin
        {rstn, wr, rd, per_clk, rtc_clk, addr, wdata} = '0;
        {alt_en, alt_dir, alt_out, evt_ch, ext_en, ext_val} = '0;
        port_clk_en = 1'b1;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_chk(ADDR_DIR, 8'hFF, RST_BYTE);
        rd_chk(ADDR_MASK0, 8'hFF, RST_BYTE);
        wr_reg(ADDR_DIR, 8'hA5);
        wr_reg(ADDR_DIRSET, 8'h02);
        rd_chk(ADDR_DIRSET, 8'hFF, 8'hA7);
        wr_reg(ADDR_DIRCLR, 8'h81);
        wr_reg(ADDR_DIRTGL, 8'h0F);
        rd_chk(ADDR_DIR, 8'hFF, 8'h29);
        chk(pin_oe_n, 8'hD6);
        wr_reg(ADDR_DIR, 8'hFF);
        wr_reg(ADDR_OUT, 8'h3C);
        wr_reg(ADDR_OUTSET, 8'h81);
        wr_reg(ADDR_OUTCLR, 8'h0C);
        wr_reg(ADDR_OUTTGL, 8'hFF);
        #1;
        chk(pin_out, 8'h4E);
        repeat (4) @(posedge mclk);
        rd_chk(ADDR_IN, 8'hFF, 8'h4E);
        rd_chk(5'h18, 8'hFF, 8'h00);
        wr_reg(ADDR_DIR, 8'h00);
        wr_reg(ADDR_MULTI, 8'h0D);
        wr_reg(ADDR_PINCFG0, 8'h8B);
        rd_chk(ADDR_PINCFG0 + 5'h3, 8'hFF, 8'h8B);
        rd_chk(ADDR_MULTI, 8'hFF, 8'h00);
        rd_chk(ADDR_PINCFG0 + 5'h1, 8'hFF, 8'h00);
        chk(pin_pull_down & 8'h0F, 8'h0D);
        wr_reg(ADDR_MASK0, 8'h01);
        wr_reg(ADDR_MASK1, 8'h01);
        ext_en <= 8'h01;
        foreach (tab[i]) begin
            @(posedge mclk);
            ext_val[0] <= tab[i][2];
            wr_reg(ADDR_PINCFG0, {1'b0, tab[i][3], 4'h0, tab[i][5:4]});
            repeat (8) @(posedge mclk);
            wr_reg(ADDR_FLAGS, 8'hFF);
            ext_val[0] <= tab[i][1];
            repeat (8) @(posedge mclk);
            rd_chk(ADDR_FLAGS, 8'h01, {7'h0, tab[i][0]});
            chk({5'h0, pin_evt[0], port_irq1, port_irq0}, {5'h0, &tab[i][5:4], tab[i][0], tab[i][0]});
        end
        wr_reg(ADDR_PINCFG0, 8'h01);
        ext_val[0] <= 1'b0;
        repeat (8) @(posedge mclk);
        wr_reg(ADDR_FLAGS, 8'hFF);
        port_clk_en <= 1'b0;
        @(posedge mclk);
        ext_val[0] <= 1'b1;
        #1;
        chk({7'h0, wake_req}, 8'h01);
        repeat (8) @(posedge mclk);
        rd_chk(ADDR_FLAGS, 8'h01, 8'h00);
        @(posedge mclk);
        port_clk_en <= 1'b1;
        @(posedge mclk);
        #1;
        chk({7'h0, wake_req}, 8'h00);
        wr_reg(ADDR_PINCFG0 + 5'h1, 8'h04);
        for (int k = 1; k >= 0; k--) begin
            @(posedge mclk);
            ext_en     <= 8'h03;
            ext_val[1] <= k[0];
            repeat (6) @(posedge mclk);
            ext_en <= 8'h01;
            repeat (4) @(posedge mclk);
            #1;
            chk({6'h0, pin_pull_up[1], pin_pull_down[1]}, {6'h0, k[0], ~k[0]});
        end
        @(posedge mclk);
        alt_en  <= 8'h05;
        alt_dir <= 8'h04;
        alt_out <= 8'h05;
        @(posedge mclk);
        #1;
        chk({6'h0, pin_oe_n[2], pin_out[2]}, 8'h01);
        for (int k = 1; k <= 2; k++) begin
            wr_reg(ADDR_CLKOUT, 8'h0C | k[7:0]);
            per_clk <= (k == 1);
            rtc_clk <= (k == 2);
            #1;
            chk({7'h0, pin_out[3]}, 8'h01);
            @(posedge mclk);
            per_clk <= (k != 1);
            rtc_clk <= (k != 2);
            #1;
            chk({7'h0, pin_out[3]}, 8'h00);
        end
        wr_reg(ADDR_EVOUT, 8'h2B);
        evt_ch <= 8'h04;
        #1;
        chk({7'h0, pin_out[5]}, 8'h01);
        @(posedge mclk);
        evt_ch <= 8'hFB;
        #1;
        chk({7'h0, pin_out[5]}, 8'h00);
        wr_reg(ADDR_REMAP, 8'h05);
        #1;
        chk({5'h0, remap_sel}, 8'h05);
        chk({5'h0, pin_oe_n[2], pin_oe_n[6], pin_out[6]}, 8'h05);
        results;
    end
endmodule
